// [logic/fsync_pkg.sv]
// Package of constants for the frame-sync serial output block
// Notes on behaviour
// RL1: Master drives frame sync, 32 clocks per frame
// RL2: Master frame sync 50-50, falls after bit 15
// RL3: Bits change on falling edge, host samples rising
// RL4: Master mode: command and chain inputs tied low
// RL5: Slave: host supplies running frame sync and clock
// RL6: Slave: serial clock never stopped by host
// RL7: Slave clock count power-of-two, enough bits
// RL8: Slave frame period must match pin setting
// RL9: Slave samples chain input on falling edge
// RL10: Word is 24 data bits plus optional 8
// RL11: Data saturates at 7FFFFF and 800000
// RL12: Status word appended unless status disabled
// RL13: Select 0: CRC4, range flag, zeros; 1: CRC8
// RL14: CRC covers data bytes only, follows data
// RL15: CRC-4 polynomial constant 0x3
// RL16: CRC-8 polynomial constant 0x07
// RL17: Clear register, XOR chunks MSB first, shift
// RL18: Host recomputes CRC, mismatch means error
// RL19: Role pin picks master or slave mode; the code has no role pin and uses config bit 2 (CFG_ROLE_BIT)
// RL20: Config bit 0 select, bit 1 disable, reset 0
// RL21: Status shifted MSB first right after data
package fsync_pkg;
    localparam int DATA_BITS = 24;
    localparam int STAT_BITS = 8;
    localparam int FRAME_BITS = 32;
    localparam int FSYNC_FALL_BIT = 15;
    localparam logic [3:0] CRC4_POLY = 4'h3;
    localparam logic [7:0] CRC8_POLY = 8'h07;
    localparam logic [23:0] CODE_MAX = 24'h7FFFFF;
    localparam logic [23:0] CODE_MIN = 24'h800000;
    localparam logic [31:0] ADDR_CONFIG = 32'h00000000;
    localparam logic [31:0] ADDR_STATUS = 32'h00000004;
    localparam logic [31:0] ADDR_DIVIDE = 32'h00000008;
    localparam int CFG_SEL_BIT = 0;
    localparam int CFG_DIS_BIT = 1;
    localparam int CFG_ROLE_BIT = 2;
    localparam logic [2:0] CONFIG_RESET = 3'h0;
    localparam logic [15:0] DIVIDE_RESET = 16'h0002;
    typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_DONE} shift_state_t;
endpackage

// [logic/crc_unit.sv]
`timescale 1ns/10ps
// Combinational CRC of the 24-bit data word, 4 or 8 bits
module crc_unit
    import fsync_pkg::*;
(
    input wire logic [23:0] data,
    output logic [3:0] crc4,
    output logic [7:0] crc8
);
    always_comb begin
        logic [3:0] r4;
        logic [7:0] r8;
        r4 = 4'h0;
        r8 = 8'h00;
        // Chunk XOR then n shift steps, implied top bit
        for (int c = 0; c < 6; c++) begin
            r4 = r4 ^ data[23 - 4*c -: 4]; // RL17
            for (int s = 0; s < 4; s++) begin
                r4 = r4[3] ? ({r4[2:0], 1'b0} ^ CRC4_POLY) : {r4[2:0], 1'b0}; // RL15
            end
        end
        for (int c = 0; c < 3; c++) begin
            r8 = r8 ^ data[23 - 8*c -: 8]; // RL17
            for (int s = 0; s < 8; s++) begin
                r8 = r8[7] ? ({r8[6:0], 1'b0} ^ CRC8_POLY) : {r8[6:0], 1'b0}; // RL16
            end
        end
        crc4 = r4;
        crc8 = r8;
    end
endmodule // crc_unit

// [logic/fsync_out.sv]
`timescale 1ns/10ps
// Frame-sync serial output: master/slave framing, clipping, status word
module fsync_out
    import fsync_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [31:0] sample_in,
    input wire logic sample_valid,
    input wire logic input_out_of_range_flag,
    input wire logic frame_sync_in,
    input wire logic sclk_in,
    input wire logic chain_data_in,
    output logic frame_sync_out,
    output logic frame_sync_oe,
    output logic sclk_out,
    output logic sclk_oe,
    output logic dout,
    output logic [31:0] chain_word
);
    logic [2:0] cfg_ff;
    logic [15:0] div_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [2:0] fs_sync_ff;
    logic [2:0] sck_sync_ff;
    logic [2:0] chn_sync_ff;
    logic [23:0] hold_ff;
    logic hold_oor_ff;
    logic [31:0] shreg_ff;
    logic [5:0] bit_ff;
    logic [15:0] div_cnt_ff;
    logic sclk_ff;
    logic fs_ff;
    logic dout_ff;
    logic [31:0] chain_ff;
    logic [31:0] chain_word_ff;
    logic frames_ff;
    shift_state_t state_ff;
    logic [3:0] crc4;
    logic [7:0] crc8;
    logic [23:0] clipped;
    logic [7:0] status;
    logic [31:0] word;
    logic master;
    logic sck_rise;
    logic sck_fall;
    logic fs_rise;
    logic sck_fall_x;
    logic frame_start;
    logic apb_done;

    assign master = cfg_ff[CFG_ROLE_BIT];
    assign apb_done = psel && penable && pready_ff;

    // Saturate wide signed sample into 24 bits
    always_comb begin
        if ($signed(sample_in) >= $signed({{8{1'b0}}, CODE_MAX})) begin
            clipped = CODE_MAX; // RL11
        end else if ($signed(sample_in) <= $signed({{8{1'b1}}, CODE_MIN})) begin
            clipped = CODE_MIN; // RL11
        end else begin
            clipped = sample_in[23:0];
        end
    end

    crc_unit u_crc (
        .data(hold_ff),
        .crc4(crc4),
        .crc8(crc8)
    );

    always_comb begin
        if (cfg_ff[CFG_SEL_BIT]) begin
            status = crc8; // RL13
        end else begin
            status = {crc4, hold_oor_ff, 3'h0}; // RL13 RL14
        end
        word = {hold_ff, cfg_ff[CFG_DIS_BIT] ? 8'h00 : status}; // RL10 RL12
    end

    // APB slave, single wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
        end else begin
            pready_ff <= psel && penable && !pready_ff;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_ff <= CONFIG_RESET; // RL20
            div_ff <= DIVIDE_RESET;
        end else if (apb_done && pwrite) begin
            if (paddr == ADDR_CONFIG) begin
                cfg_ff <= pwdata[2:0]; // RL20
            end else if (paddr == ADDR_DIVIDE) begin
                div_ff <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h00000000;
            pslverr_ff <= 1'b0;
        end else if (psel && penable && !pready_ff) begin
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
            if (paddr == ADDR_CONFIG) begin
                prdata_ff <= {29'h0, cfg_ff};
            end else if (paddr == ADDR_STATUS) begin
                prdata_ff <= {24'h0, hold_oor_ff, frames_ff, bit_ff};
            end else if (paddr == ADDR_DIVIDE) begin
                prdata_ff <= {16'h0, div_ff};
            end else begin
                pslverr_ff <= 1'b1;
            end
        end else begin
            pslverr_ff <= 1'b0;
        end
    end

    // Two-flop synchronisers plus an edge stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fs_sync_ff <= 3'h0;
            sck_sync_ff <= 3'h0;
            chn_sync_ff <= 3'h0;
        end else begin
            fs_sync_ff <= {fs_sync_ff[1:0], frame_sync_in};
            sck_sync_ff <= {sck_sync_ff[1:0], sclk_in};
            chn_sync_ff <= {chn_sync_ff[1:0], chain_data_in};
        end
    end

    assign fs_rise = fs_sync_ff[1] && !fs_sync_ff[2];
    assign sck_rise = sck_sync_ff[1] && !sck_sync_ff[2];
    assign sck_fall_x = !sck_sync_ff[1] && sck_sync_ff[2];

    // Master clock divider: half period of div_ff pclk cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_ff <= 16'h0000;
            sclk_ff <= 1'b0;
        end else if (!master) begin
            div_cnt_ff <= 16'h0000;
            sclk_ff <= 1'b0;
        end else if (div_cnt_ff >= div_ff - 16'h0001) begin
            div_cnt_ff <= 16'h0000;
            sclk_ff <= !sclk_ff; // RL1
        end else begin
            div_cnt_ff <= div_cnt_ff + 16'h0001;
        end
    end

    assign sck_fall = master ? (sclk_ff && div_cnt_ff >= div_ff - 16'h0001) : sck_fall_x;
    // Master frame begins on the falling edge after bit 31
    // Counter past the last bit (left from slave mode) also starts a frame
    assign frame_start = master ? (sck_fall && bit_ff >= 6'(FRAME_BITS - 1)) : fs_rise;

    // Latch newest sample; the shift register keeps the frame copy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_ff <= 24'h000000;
            hold_oor_ff <= 1'b0;
        end else if (sample_valid) begin
            hold_ff <= clipped;
            hold_oor_ff <= input_out_of_range_flag;
        end
    end

    // Shift engine: MSB at frame start, next bit each falling edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shreg_ff <= 32'h00000000;
            bit_ff <= 6'(FRAME_BITS - 1);
            state_ff <= ST_IDLE;
            fs_ff <= 1'b0;
            frames_ff <= 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (frame_start) begin
                        shreg_ff <= word; // RL5 RL3
                        bit_ff <= 6'h00;
                        fs_ff <= master; // RL2
                        state_ff <= ST_SHIFT;
                        frames_ff <= 1'b1;
                    end
                end
                ST_SHIFT: begin
                    if (frame_start) begin
                        shreg_ff <= word;
                        bit_ff <= 6'h00;
                        fs_ff <= master;
                    end else if (sck_fall) begin
                        shreg_ff <= {shreg_ff[30:0], 1'b0}; // RL3 RL21
                        bit_ff <= bit_ff + 6'h01;
                        if (bit_ff == 6'(FRAME_BITS - FSYNC_FALL_BIT - 2)) begin
                            fs_ff <= 1'b0; // RL2
                        end
                        if (bit_ff == 6'(FRAME_BITS - 1) && !master) begin
                            state_ff <= ST_DONE;
                        end
                    end
                end
                ST_DONE: begin
                    if (frame_start) begin
                        shreg_ff <= word;
                        bit_ff <= 6'h00;
                        fs_ff <= master; // RL2
                        state_ff <= ST_SHIFT;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dout_ff <= 1'b0;
        end else begin
            dout_ff <= (state_ff == ST_SHIFT) ? shreg_ff[31] : 1'b0;
        end
    end

    // Chain input captured on falling edges in slave mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chain_ff <= 32'h00000000;
            chain_word_ff <= 32'h00000000;
        end else if (!master) begin
            if (sck_fall_x) begin
                chain_ff <= {chain_ff[30:0], chn_sync_ff[1]}; // RL9
            end
            if (fs_rise) begin
                chain_word_ff <= chain_ff;
            end
        end
    end

    // Output enables follow the frame role
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_sync_oe <= 1'b0;
            sclk_oe <= 1'b0;
        end else begin
            frame_sync_oe <= master; // RL1
            sclk_oe <= master;
        end
    end

    // Master pins, one cycle behind their sources like dout
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_sync_out <= 1'b0;
            sclk_out <= 1'b0;
        end else begin
            frame_sync_out <= fs_ff; // RL2
            sclk_out <= sclk_ff; // RL1
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign dout = dout_ff;
    assign chain_word = chain_word_ff;
endmodule // fsync_out

// [verif/fsync_out_assertions.sv]
// Checker of the frame-sync output block's port timing
`timescale 1ns/10ps
module fsync_out_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic frame_sync_out,
    input wire logic frame_sync_oe,
    input wire logic sclk_out,
    input wire logic sclk_oe,
    input wire logic dout
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_wait_a: assert property (psel && penable && !pready |=> pready) else $error("ready late");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
    ready_access_a: assert property (pready |-> psel && penable) else $error("stray ready");
    error_ready_a: assert property (pslverr |-> pready) else $error("stray error");
    rdata_hold_a: assert property ($changed(prdata) |-> pready) else $error("read data moved");
    pin_enable_a: assert property (frame_sync_oe == sclk_oe) else $error("enables differ");
    sync_fall_a: assert property (frame_sync_oe && $fell(frame_sync_out) |-> $fell(sclk_out))
        else $error("sync fall off edge");
    sync_rise_a: assert property (frame_sync_oe && $rose(frame_sync_out) |-> !sclk_out)
        else $error("sync rise off edge");
    dout_hold_a: assert property (frame_sync_oe && sclk_out && $past(sclk_out) |-> $stable(dout))
        else $error("data moved high");
endmodule // fsync_out_checker
bind fsync_out fsync_out_checker i_chk (.pclk, .presetn, .psel, .penable, .prdata, .pready, .pslverr,
    .frame_sync_out, .frame_sync_oe, .sclk_out, .sclk_oe, .dout);

// [verif/fsync_host_model.sv]
// Host model: free-running serial clock, frame sync, word capture
`timescale 1ns/10ps
module fsync_host_model (
    input wire logic dout,
    input wire logic role_master,
    output logic frame_sync_in,
    output logic sclk_in,
    output logic chain_data_in,
    output logic [31:0] rx,
    output int nframes
);
    localparam logic [31:0] CHAIN_PAT = 32'hC3A50F96;
    initial begin
        sclk_in = 0;
        frame_sync_in = 0;
        chain_data_in = 0;
        rx = '0;
        nframes = 0;
        forever #80 sclk_in = ~sclk_in;
    end
    // 64 clocks per frame, word in the first 32
    initial begin
        wait (sclk_in === 1'b1);
        @(negedge sclk_in);
        forever begin
            #40 frame_sync_in = 1;
            for (int i = 0; i < 64; i++) begin
                @(posedge sclk_in);
                if (i < 32) rx = {rx[30:0], dout};
                if (i == 31) nframes++;
                chain_data_in = role_master ? 1'b0 : CHAIN_PAT[31 - i % 32];
                @(negedge sclk_in);
                if (i == 15) frame_sync_in = 0;
            end
        end
    end
endmodule // fsync_host_model

// [verif/fsync_out_tb.sv]
// Testbench of the frame-sync serial output block
`timescale 1ns/10ps
module fsync_out_tb;
    import fsync_pkg::*;
    typedef struct packed {
        logic [2:0] cfg;
        logic [31:0] s;
        logic oor;
        logic [23:0] d;
    } row_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sample_valid, input_out_of_range_flag;
    logic [31:0] paddr, pwdata, prdata, sample_in, chain_word, rx, q;
    logic frame_sync_in, sclk_in, chain_data_in, frame_sync_out, frame_sync_oe, sclk_out, sclk_oe, dout;
    logic e, pf, ps, rs;
    int nframes, num_errors, total_checks, cyc, n, h, t;
    logic [31:0] mw;
    row_t mr;
    row_t rows[6] = '{'{3'h0, 32'h00123456, 1'h1, 24'h123456}, '{3'h1, 32'h01000000, 1'h0, 24'h7FFFFF},
        '{3'h0, 32'hFF000000, 1'h0, 24'h800000}, '{3'h2, 32'hFFFFFFFF, 1'h1, 24'hFFFFFF},
        '{3'h3, 32'h007FFFFF, 1'h0, 24'h7FFFFF}, '{3'h1, 32'hFF800000, 1'h1, 24'h800000}};
    fsync_out i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .sample_in, .sample_valid, .input_out_of_range_flag, .frame_sync_in, .sclk_in, .chain_data_in,
        .frame_sync_out, .frame_sync_oe, .sclk_out, .sclk_oe, .dout, .chain_word);
    fsync_host_model i_host (.dout, .role_master(frame_sync_oe), .frame_sync_in, .sclk_in, .chain_data_in, .rx,
        .nframes);
    initial begin
        pclk = 0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 60000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'h1);
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic wait_frame;
        int m0;
        m0 = nframes;
        while (nframes == m0) @(posedge pclk);
    endtask
    function automatic logic [7:0] crc(input logic [23:0] x, input int nb);
        logic [7:0] r8, m, p;
        r8 = 0;
        m = nb == 4 ? 8'h0F : 8'hFF;
        p = nb == 4 ? {4'h0, CRC4_POLY} : CRC8_POLY;
        for (int c = 24 - nb; c >= 0; c -= nb) begin
            r8 = r8 ^ (8'(x >> c) & m);
            for (int k = 0; k < nb; k++) r8 = (r8[nb - 1] ? (r8 << 1) ^ p : r8 << 1) & m;
        end
        return r8;
    endfunction
    function automatic logic [31:0] exp_word(input row_t w);
        logic [7:0] c4;
        c4 = crc(w.d, 4);
        if (w.cfg[1]) return {w.d, 8'h00};
        if (w.cfg[0]) return {w.d, crc(w.d, 8)};
        return {w.d, c4[3:0], w.oor, 3'h0};
    endfunction
    task tally_and_finish;
        $display("errors %0d checks %0d", num_errors, total_checks);
        if (num_errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        presetn = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = '0;
        pwdata = '0;
        sample_in = '0;
        sample_valid = 0;
        input_out_of_range_flag = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1;
        apb(0, ADDR_CONFIG, 32'h0);
        chk(q, 32'h0);
        apb(0, ADDR_DIVIDE, 32'h0);
        chk(q, {16'h0, DIVIDE_RESET});
        apb(0, 32'h0000000C, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(0, ADDR_STATUS, 32'h0);
        chk(q, {26'h0, 6'(FRAME_BITS - 1)});
        wait_frame();
        foreach (rows[i]) begin
            repeat (40) @(posedge pclk);
            apb(1, ADDR_CONFIG, {29'h0, rows[i].cfg});
            @(posedge pclk);
            sample_in <= rows[i].s;
            input_out_of_range_flag <= rows[i].oor;
            sample_valid <= 1;
            @(posedge pclk);
            sample_valid <= 0;
            wait_frame();
            chk(rx, exp_word(rows[i]));
        end
        chk(chain_word, 32'hC3A50F96);
        // Master: second pass measures one whole frame and its word
        apb(1, ADDR_CONFIG, 32'h00000004);
        mr = rows[5];
        mr.cfg = 3'h4;
        pf = 1;
        ps = 0;
        mw = '0;
        repeat (2) begin
            n = 0;
            h = 0;
            t = 0;
            do begin
                @(negedge pclk);
                n += int'(sclk_out && !ps);
                h += int'(frame_sync_out);
                t++;
                if (sclk_out && !ps) mw = {mw[30:0], dout};
                rs = frame_sync_out && !pf;
                ps = sclk_out;
                pf = frame_sync_out;
            end while (!rs && t < 2000);
        end
        chk(n, 32);
        chk(2 * h, t);
        chk(t, 2 * FRAME_BITS * int'(DIVIDE_RESET));
        chk(mw, exp_word(mr));
        chk({31'h0, frame_sync_oe && sclk_oe}, 32'h1);
        // Reset in mid-frame: pins released, config back to reset
        @(posedge pclk);
        presetn <= 0;
        repeat (2) @(posedge pclk);
        chk({29'h0, frame_sync_oe, sclk_oe, dout}, 32'h0);
        presetn <= 1;
        apb(0, ADDR_CONFIG, 32'h0);
        chk(q, 32'h0);
        tally_and_finish();
    end
endmodule // fsync_out_tb
